/* File: cmrb_pkg.sv */
/*
 package for the configuration memory readback sequencer: packet words,
 command codes, port widths and counts.
 assumes a single clock domain and a host that keeps its own sequence.
*/
//Behaviour
//- frame data passes the frame buffer; first returned frame is a dummy
//- done output low while shutdown is in progress
//- 8-bit port: requested count is words wanted plus one
//- returned words equal words per frame times frames plus one
//- 8-bit port returns one extra word beyond frame-based length
//- 42 dummy words first in 32-bit; doubled 16-bit, quadrupled 8-bit
//- read-to-wait latency 1 clock 8-bit, 3 16-bit, 4 32-bit
//- direction low: host writes, pins in; high: host reads, pins out
package cmrb_pkg;
	localparam logic [31:0] SYNC_WORD      = 32'hAA99_5566;
	localparam logic [31:0] NOOP_WORD      = 32'h2000_0000;
	localparam logic [31:0] HDR_CMD_WR1    = 32'h3000_8001;
	localparam logic [31:0] HDR_FAR_WR1    = 32'h3000_2001;
	localparam logic [31:0] HDR_FRAME_DATA_OUT_REG_RD0   = 32'h2800_6000;
	localparam logic [31:0] HDR_T2_MASK    = 32'hF800_0000;
	localparam logic [31:0] HDR_T2_RD      = 32'h4800_0000;
	localparam logic [31:0] T2_CNT_MASK    = 32'h07FF_FFFF;
	localparam logic [4:0]  CMD_SHUTDOWN   = 5'h0B;
	localparam logic [4:0]  CMD_START      = 5'h05;
	localparam logic [4:0]  CMD_CRC_RESET  = 5'h07;
	localparam logic [4:0]  CMD_RB_SETUP   = 5'h04;
	localparam logic [4:0]  CMD_DESYNC     = 5'h0D;
	localparam logic [1:0]  W8             = 2'h0;
	localparam logic [1:0]  W16            = 2'h1;
	localparam logic [1:0]  W32            = 2'h2;
	localparam logic [3:0]  LAT_W8         = 4'h1;
	localparam logic [3:0]  LAT_W16        = 4'h3;
	localparam logic [3:0]  LAT_W32        = 4'h4;
	localparam logic [7:0]  DUMMY_W32      = 8'h2A;
	localparam logic [7:0]  SHUTDOWN_CYC   = 8'h10;
	localparam logic [31:0] DUMMY_DATA     = 32'h0000_0000;
	localparam logic [15:0] IMAGE_TAG      = 16'hC0DE;

	typedef enum logic [4:0] {
		CMRB_IDLE  = 5'b00001,
		CMRB_HDR   = 5'b00010,
		CMRB_CMD   = 5'b00100,
		CMRB_FAR   = 5'b01000,
		CMRB_T2    = 5'b10000
	} cmrb_pkt_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} cmrb_word_t;
endpackage

/* File: cmrb_frame_mem.sv */
/*
 frame store: configuration memory image, one word per address.
 assumes a synchronous single-port read and no writes from the port.
*/
`timescale 1ns/1ps
module cmrb_frame_mem #(
	parameter int AW = 10
) (
	input  wire logic          clk_sys_i,
	input  wire logic [AW-1:0] addr_i,
	output logic      [31:0]   rdata_o
);
	logic [31:0] mem [0:(1<<AW)-1];

	// image pattern, address-dependent
	always_comb begin
		for (int i = 0; i < (1<<AW); i++) begin
			mem[i] = {cmrb_pkg::IMAGE_TAG, i[15:0]};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		rdata_o <= mem[addr_i];
	end
endmodule

/* File: cmrb_fifo.sv */
/*
 output fifo between the readback engine and the port.
 assumes one clock; drain side may stall.
*/
`timescale 1ns/1ps
module cmrb_fifo #(
	parameter int W = 32,
	parameter int D = 16
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rst_n_i,
	input  wire logic         flush_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic      [W-1:0] out_data_o
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_r [0:D-1];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          wr;
	logic          rd;

	assign in_ready_o  = (cnt_r != D[AW:0]);
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o  = mem_r[rp_r];
	assign wr = in_valid_i && in_ready_o;
	assign rd = out_valid_o && out_ready_i;

	always_ff @(posedge clk_sys_i) begin
		if (wr) begin
			mem_r[wp_r] <= in_data_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || flush_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (wr) begin
				wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
			end
			if (rd) begin
				rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end
endmodule

/* File: cmrb_top.sv */
/*
 configuration memory readback: packet decode on the parallel port,
 shutdown/start done handling, frame readback with dummy words and frame.
 the frame store is addressed with the next frame pointer, so its registered
 read data always belong to the current pointer, stalls included.
 assumes host keeps the command sequence and changes direction with select high.
 assumes readback is only started once the shutdown delay has run out.
*/
`timescale 1ns/1ps
module cmrb_top #(
	parameter int WORDS_PER_FRAME = 41,
	parameter int MEM_AW          = 10,
	parameter int FIFO_DEPTH      = 16
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic        sel_n_i,
	input  wire logic        direction_select_i,
	input  wire logic [1:0]  width_i,
	input  wire logic [31:0] data_i,
	output logic      [31:0] data_o,
	output logic      [31:0] data_oe_o,
	output logic             rb_wait_o,
	output logic             done_o
);
	cmrb_pkg::cmrb_pkt_t pkt_r;
	logic                synced_r;
	logic                done_r;
	logic [7:0]          shut_cnt_r;
	logic                dir_r;
	logic                abort_r;
	logic [26:0]         rd_left_r;
	logic [26:0]         req_cnt_r;
	logic [3:0]          lat_r;
	logic [9:0]          dummy_r;
	logic [MEM_AW-1:0]   addr_r;
	logic [MEM_AW-1:0]   addr_nxt;
	logic [15:0]         wcnt_r;
	logic                fill_r;
	logic                mem_vld_r;
	logic [31:0]         mem_q;
	logic                wr_word;
	logic                reading;
	cmrb_pkg::cmrb_word_t src;
	logic                src_rdy;
	logic                out_vld;
	logic [31:0]         out_dat;
	logic [3:0]          lat_nxt;
	logic [9:0]          dummy_nxt;

	assign wr_word = !sel_n_i && !direction_select_i;
	assign reading = !sel_n_i && direction_select_i && dir_r;

	// latency and dummy count per width
	always_comb begin
		case (width_i)
			cmrb_pkg::W8: begin
				lat_nxt   = cmrb_pkg::LAT_W8;
				dummy_nxt = {cmrb_pkg::DUMMY_W32, 2'b00};
			end
			cmrb_pkg::W16: begin
				lat_nxt   = cmrb_pkg::LAT_W16;
				dummy_nxt = {1'b0, cmrb_pkg::DUMMY_W32, 1'b0};
			end
			default: begin
				lat_nxt   = cmrb_pkg::LAT_W32;
				dummy_nxt = {2'b00, cmrb_pkg::DUMMY_W32};
			end
		endcase
	end

	// sync detect and packet decode
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			synced_r  <= 1'b0;
			pkt_r     <= cmrb_pkg::CMRB_IDLE;
			req_cnt_r <= '0;
		end else if (wr_word) begin
			if (!synced_r) begin
				synced_r <= (data_i == cmrb_pkg::SYNC_WORD);
			end else begin
				case (pkt_r)
					cmrb_pkg::CMRB_IDLE, cmrb_pkg::CMRB_HDR: begin
						if (data_i == cmrb_pkg::HDR_CMD_WR1) begin
							pkt_r <= cmrb_pkg::CMRB_CMD;
						end else if (data_i == cmrb_pkg::HDR_FAR_WR1) begin
							pkt_r <= cmrb_pkg::CMRB_FAR;
						end else if (data_i == cmrb_pkg::HDR_FRAME_DATA_OUT_REG_RD0) begin
							pkt_r <= cmrb_pkg::CMRB_T2;
						end else begin
							pkt_r <= cmrb_pkg::CMRB_HDR;
						end
					end
					cmrb_pkg::CMRB_CMD: begin
						pkt_r <= cmrb_pkg::CMRB_HDR;
						if (data_i[4:0] == cmrb_pkg::CMD_DESYNC) begin
							synced_r <= 1'b0;
						end
					end
					cmrb_pkg::CMRB_T2: begin
						pkt_r <= cmrb_pkg::CMRB_HDR;
						if ((data_i & cmrb_pkg::HDR_T2_MASK) == cmrb_pkg::HDR_T2_RD) begin
							req_cnt_r <= 27'(data_i & cmrb_pkg::T2_CNT_MASK);
						end
					end
					default: begin
						pkt_r <= cmrb_pkg::CMRB_HDR;
					end
				endcase
			end
		end
	end

	// shutdown and start drive done
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			done_r     <= 1'b1;
			shut_cnt_r <= '0;
		end else if (wr_word && synced_r && pkt_r == cmrb_pkg::CMRB_CMD) begin
			if (data_i[4:0] == cmrb_pkg::CMD_SHUTDOWN) begin
				done_r     <= 1'b0;
				shut_cnt_r <= cmrb_pkg::SHUTDOWN_CYC;
			end else if (data_i[4:0] == cmrb_pkg::CMD_START) begin
				done_r <= 1'b1;
			end
		end else if (shut_cnt_r != '0) begin
			shut_cnt_r <= shut_cnt_r - 8'h01;
		end
	end
	assign done_o = done_r;

	// next frame pointer, also the frame store address
	always_comb begin
		addr_nxt = addr_r;
		if (wr_word && synced_r && pkt_r == cmrb_pkg::CMRB_FAR) begin
			addr_nxt = MEM_AW'(data_i);
		end else if (fill_r && src_rdy && dummy_r == '0
			&& wcnt_r >= 16'(WORDS_PER_FRAME)) begin
			addr_nxt = addr_r + 1'b1;
		end
	end

	// start address and frame pointer
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			addr_r <= '0;
			wcnt_r <= '0;
		end else if (wr_word && synced_r && pkt_r == cmrb_pkg::CMRB_FAR) begin
			addr_r <= addr_nxt;
			wcnt_r <= '0;
		end else if (fill_r && src_rdy && dummy_r == '0) begin
			if (wcnt_r < 16'(WORDS_PER_FRAME)) begin
				wcnt_r <= wcnt_r + 16'h0001;
			end else begin
				addr_r <= addr_nxt;
			end
		end
	end

	// direction change, read latency, fill control
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			dir_r     <= 1'b0;
			abort_r   <= 1'b0;
			lat_r     <= '0;
			dummy_r   <= '0;
			fill_r    <= 1'b0;
			rd_left_r <= '0;
		end else begin
			dir_r   <= direction_select_i;
			abort_r <= !sel_n_i && (dir_r != direction_select_i);
			// readback only starts if the shutdown delay has run out at the direction change
			if (direction_select_i && !dir_r && sel_n_i && shut_cnt_r == '0) begin
				lat_r   <= lat_nxt;
				dummy_r <= dummy_nxt;
				// requested word count plus dummy frame, one more word at 8 bits
				rd_left_r <= req_cnt_r + 27'(WORDS_PER_FRAME)
					+ ((width_i == cmrb_pkg::W8) ? 27'h1 : 27'h0);
				fill_r  <= 1'b0;
			end else if (lat_r != '0) begin
				lat_r <= lat_r - 4'h1;
				fill_r <= (lat_r == 4'h1);
			end else if (fill_r && src_rdy) begin
				if (dummy_r != '0) begin
					dummy_r <= dummy_r - 10'h001;
				end else if (rd_left_r != '0) begin
					rd_left_r <= rd_left_r - 27'h1;
				end else begin
					fill_r <= 1'b0;
				end
			end
			if (!direction_select_i || abort_r) begin
				fill_r <= 1'b0;
			end
		end
	end

	cmrb_frame_mem #(
		.AW (MEM_AW)
	) u_mem (
		.clk_sys_i (clk_sys_i),
		.addr_i    (addr_nxt),
		.rdata_o   (mem_q)
	);

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			mem_vld_r <= 1'b0;
		end else begin
			mem_vld_r <= fill_r && dummy_r == '0 && rd_left_r != '0;
		end
	end

	// dummy words and the buffer frame come out as dummy data
	always_comb begin
		src.valid = fill_r && (dummy_r != '0 || rd_left_r != '0);
		src.data  = (dummy_r != '0 || wcnt_r < 16'(WORDS_PER_FRAME) || !mem_vld_r)
			? cmrb_pkg::DUMMY_DATA : mem_q;
	end

	cmrb_fifo #(
		.W (32),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i   (clk_sys_i),
		.rst_n_i     (rst_n_i),
		.flush_i     (!direction_select_i),
		.in_valid_i  (src.valid),
		.in_ready_o  (src_rdy),
		.in_data_i   (src.data),
		.out_valid_o (out_vld),
		.out_ready_i (reading),
		.out_data_o  (out_dat)
	);

	// port outputs; wait high while no word is ready
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			data_o <= '0;
		end else if (reading && out_vld) begin
			data_o <= out_dat;
		end
	end
	assign data_oe_o = {32{direction_select_i && !sel_n_i}};
	assign rb_wait_o = !(out_vld && direction_select_i);
endmodule

/* File: cmrb_top_properties.sv */
/* port checker for cmrb_top.
 assumes one clock and a sync reset; bound below. */
`timescale 1ns/1ps
module cmrb_top_properties #(
	parameter int WORDS_PER_FRAME = 41
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic        sel_n_i,
	input  wire logic        direction_select_i,
	input  wire logic [1:0]  width_i,
	input  wire logic [31:0] data_i,
	input  wire logic [31:0] data_o,
	input  wire logic [31:0] data_oe_o,
	input  wire logic        rb_wait_o,
	input  wire logic        done_o
);
	logic        wr;
	logic        rd;
	logic        synced_r;
	logic        cmd_hdr_r;
	logic [31:0] cnt_r;
	logic [31:0] rd_r;
	logic [31:0] dum;
	logic [31:0] tot;
	assign wr = !sel_n_i && !direction_select_i;
	assign rd = !sel_n_i && direction_select_i && !rb_wait_o;
	assign dum = (width_i == cmrb_pkg::W8) ? 32'h0000_00A8 :
		(width_i == cmrb_pkg::W16) ? 32'h0000_0054 : 32'h0000_002A;
	assign tot = dum + cnt_r + 32'(WORDS_PER_FRAME) + {31'h0, width_i == cmrb_pkg::W8};
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			synced_r <= 1'b0;
		else if (wr && cmd_hdr_r && data_i == {27'h0, cmrb_pkg::CMD_DESYNC})
			synced_r <= 1'b0;
		else if (wr && data_i == cmrb_pkg::SYNC_WORD)
			synced_r <= 1'b1;
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			cmd_hdr_r <= 1'b0;
		else if (wr)
			cmd_hdr_r <= synced_r && !cmd_hdr_r && data_i == cmrb_pkg::HDR_CMD_WR1;
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			cnt_r <= '0;
		else if (synced_r && wr && (data_i & cmrb_pkg::HDR_T2_MASK) == cmrb_pkg::HDR_T2_RD)
			cnt_r <= data_i & cmrb_pkg::T2_CNT_MASK;
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || !direction_select_i)
			rd_r <= '0;
		else if (rd)
			rd_r <= rd_r + 32'h0000_0001;
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	chk_oe_drive: assert property (rd || (!sel_n_i && direction_select_i) |-> &data_oe_o)
		else $error("pins not driven while reading");
	chk_oe_release: assert property (!direction_select_i |-> data_oe_o == '0)
		else $error("pins driven while writing");
	chk_done_shut: assert property (synced_r && wr && data_i == cmrb_pkg::HDR_CMD_WR1 ##1
		wr && data_i == {27'h0, cmrb_pkg::CMD_SHUTDOWN} |=> !done_o)
		else $error("done high after shutdown");
	chk_done_start: assert property (synced_r && wr && data_i == cmrb_pkg::HDR_CMD_WR1 ##1
		wr && data_i == {27'h0, cmrb_pkg::CMD_START} |-> ##[1:40] done_o)
		else $error("done not back after start");
	chk_wait_x32: assert property ($rose(direction_select_i) && width_i == cmrb_pkg::W32
		|-> rb_wait_o [*4] ##[1:20] !rb_wait_o)
		else $error("wait latency wrong at x32");
	chk_wait_x16: assert property ($rose(direction_select_i) && width_i == cmrb_pkg::W16
		|-> rb_wait_o [*3] ##[1:20] !rb_wait_o)
		else $error("wait latency wrong at x16");
	chk_wait_x8: assert property ($rose(direction_select_i) && width_i == cmrb_pkg::W8
		|-> rb_wait_o ##[1:20] !rb_wait_o)
		else $error("wait latency wrong at x8");
	chk_dummy_words: assert property (rd && rd_r < dum |=> data_o == cmrb_pkg::DUMMY_DATA)
		else $error("dummy word not zero");
	chk_dummy_frame: assert property (rd && rd_r >= dum && rd_r < dum + 32'(WORDS_PER_FRAME)
		|=> data_o == cmrb_pkg::DUMMY_DATA)
		else $error("buffer frame not zero");
	chk_read_len: assert property (direction_select_i && rd_r == tot |-> rb_wait_o)
		else $error("word beyond read length");
	chk_data_hold: assert property (!rd |=> $stable(data_o))
		else $error("read word changed untaken");
endmodule
bind cmrb_top cmrb_top_properties #(.WORDS_PER_FRAME(WORDS_PER_FRAME)) cmrb_top_properties_i (
	.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sel_n_i(sel_n_i),
	.direction_select_i(direction_select_i), .width_i(width_i), .data_i(data_i),
	.data_o(data_o), .data_oe_o(data_oe_o), .rb_wait_o(rb_wait_o), .done_o(done_o));

/* File: cmrb_host_model.sv */
/* host model driving the parallel port.
 assumes the device answers on the same clock. */
`timescale 1ns/1ps
module cmrb_host_model (
	input  wire logic        clk_sys_i,
	input  wire logic        rb_wait_i,
	input  wire logic [31:0] rdata_i,
	output logic             sel_n_o,
	output logic             dir_o,
	output logic      [1:0]  width_o,
	output logic      [31:0] wdata_o
);
	logic        take_q;
	logic [31:0] words[$];
	initial begin
		sel_n_o = 1'b1;
		dir_o = 1'b0;
		width_o = cmrb_pkg::W32;
		wdata_o = '0;
		take_q = 1'b0;
	end
	always @(posedge clk_sys_i) begin
		if (take_q)
			words.push_back(rdata_i);
		take_q <= !sel_n_o && dir_o && !rb_wait_i;
	end
	task automatic wr(input logic [31:0] w);
		@(posedge clk_sys_i);
		sel_n_o <= 1'b0;
		dir_o <= 1'b0;
		wdata_o <= w;
	endtask
	task automatic idle(input int n);
		@(posedge clk_sys_i);
		sel_n_o <= 1'b1;
		wdata_o <= ~wdata_o;
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic cmd(input logic [4:0] c);
		wr(cmrb_pkg::HDR_CMD_WR1);
		wr({27'h0, c});
		wr(cmrb_pkg::NOOP_WORD);
	endtask
	task automatic shut();
		wr(32'hFFFF_FFFF);
		wr(32'h0000_00BB);
		wr(32'h1122_0044);
		wr(32'hFFFF_FFFF);
		wr(cmrb_pkg::SYNC_WORD);
		wr(cmrb_pkg::NOOP_WORD);
		cmd(cmrb_pkg::CMD_SHUTDOWN);
		cmd(cmrb_pkg::CMD_CRC_RESET);
		repeat (5) wr(cmrb_pkg::NOOP_WORD);
	endtask
	task automatic setup(input logic [31:0] cnt);
		cmd(cmrb_pkg::CMD_RB_SETUP);
		wr(cmrb_pkg::HDR_FAR_WR1);
		wr('0);
		wr(cmrb_pkg::HDR_FRAME_DATA_OUT_REG_RD0);
		wr(cmrb_pkg::HDR_T2_RD | cnt);
		repeat (32) wr(cmrb_pkg::NOOP_WORD);
	endtask
	task automatic fetch();
		int i;
		int quiet;
		bit st;
		words = {};
		quiet = 0;
		st = 0;
		@(posedge clk_sys_i);
		sel_n_o <= 1'b1;
		dir_o <= 1'b1;
		wdata_o <= ~wdata_o;
		@(posedge clk_sys_i);
		sel_n_o <= 1'b0;
		for (i = 0; i < 3000 && quiet < 40; i++) begin
			@(posedge clk_sys_i);
			quiet = rb_wait_i ? quiet + 1 : 0;
			if (words.size() == 8 && !st) begin
				st = 1;
				sel_n_o <= 1'b1;
				repeat (30) @(posedge clk_sys_i);
				sel_n_o <= 1'b0;
			end
		end
		@(posedge clk_sys_i);
		sel_n_o <= 1'b1;
		dir_o <= 1'b0;
	endtask
	task automatic finish();
		wr(cmrb_pkg::NOOP_WORD);
		cmd(cmrb_pkg::CMD_START);
		cmd(cmrb_pkg::CMD_CRC_RESET);
		wr(cmrb_pkg::HDR_CMD_WR1);
		wr({27'h0, cmrb_pkg::CMD_DESYNC});
		wr(cmrb_pkg::NOOP_WORD);
		wr(cmrb_pkg::NOOP_WORD);
		idle(1);
	endtask
endmodule

/* File: tb_top.sv */
/* testbench for cmrb_top with the host model.
 assumes 10 MHz clock and small frames. */
`timescale 1ns/1ps
module tb_top;
	localparam int WPF = 4;
	logic        clk_sys_i;
	logic        rst_n_i;
	logic        sel_n;
	logic        dir;
	logic [1:0]  width;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        rb_wait;
	logic        done;
	int          fail_count;
	int          n_tests;
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	cmrb_top #(.WORDS_PER_FRAME(WPF)) cmrb_top_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.sel_n_i(sel_n), .direction_select_i(dir), .width_i(width), .data_i(wdata),
		.data_o(rdata), .data_oe_o(), .rb_wait_o(rb_wait), .done_o(done));
	cmrb_host_model cmrb_host_model_i (.clk_sys_i(clk_sys_i), .rb_wait_i(rb_wait),
		.rdata_i(rdata), .sel_n_o(sel_n), .dir_o(dir), .width_o(width), .wdata_o(wdata));
	task automatic check(input bit ok, input string msg);
		n_tests++;
		if (!ok) begin
			fail_count++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task automatic do_reset(input logic [1:0] w);
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		cmrb_host_model_i.width_o <= w;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
	endtask
	task automatic t_nosync();
		do_reset(cmrb_pkg::W32);
		cmrb_host_model_i.cmd(cmrb_pkg::CMD_SHUTDOWN);
		cmrb_host_model_i.idle(20);
		check(done === 1'b1, "shutdown taken before sync");
	endtask
	task automatic t_readback(input logic [1:0] w);
		int i;
		int dum;
		int cnt;
		int exp_len;
		bit ok;
		do_reset(w);
		dum = (w == cmrb_pkg::W8) ? 168 : (w == cmrb_pkg::W16) ? 84 : 42;
		cnt = WPF * 2 + int'(w == cmrb_pkg::W8);
		cmrb_host_model_i.shut();
		check(done === 1'b0, "done high in shutdown");
		cmrb_host_model_i.setup(cnt);
		cmrb_host_model_i.fetch();
		exp_len = dum + cnt + WPF + int'(w == cmrb_pkg::W8);
		check(cmrb_host_model_i.words.size() == exp_len, "read length");
		ok = 1;
		for (i = 0; i < dum + WPF && i < cmrb_host_model_i.words.size(); i++)
			ok &= (cmrb_host_model_i.words[i] === cmrb_pkg::DUMMY_DATA);
		check(ok, "leading dummy data not zero");
		ok = 1;
		for (i = 0; i < cnt && dum + WPF + i < cmrb_host_model_i.words.size(); i++)
			ok &= (cmrb_host_model_i.words[dum + WPF + i] === {cmrb_pkg::IMAGE_TAG, 16'(i)});
		check(ok, "frame data out of order");
		cmrb_host_model_i.finish();
		for (i = 0; i < 100 && done !== 1'b1; i++)
			@(posedge clk_sys_i);
		check(done === 1'b1, "done not restored");
		cmrb_host_model_i.cmd(cmrb_pkg::CMD_SHUTDOWN);
		cmrb_host_model_i.idle(4);
		check(done === 1'b1, "shutdown taken after desync");
	endtask
	task automatic complete_run();
		$display("tests %0d errors %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#2000000;
		fail_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		complete_run();
	end
	initial begin
		rst_n_i = 1'b0;
		fail_count = 0;
		n_tests = 0;
		t_nosync();
		t_readback(cmrb_pkg::W32);
		t_readback(cmrb_pkg::W16);
		t_readback(cmrb_pkg::W8);
		complete_run();
	end
endmodule
